// ===== rtl/cbsc_consts.vh
// Constants for the converter B step 14/15 configuration block.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef CBSC_CONSTS_VH
`define CBSC_CONSTS_VH
// Register indices as printed (not multiples of four); byte address is index times four.
`define CBSC_IDX_STEP14 8'hDE
`define CBSC_IDX_STEP15 8'hDF
`define CBSC_ADDR_STEP14 12'h378
`define CBSC_ADDR_STEP15 12'h37C
`define CBSC_RST_STEP14 16'h000E
`define CBSC_RST_STEP15 16'h000F
// Field positions.
`define CBSC_EN_BIT 15
`define CBSC_GAIN_HI 14
`define CBSC_GAIN_LO 13
`define CBSC_NEG_BIT 4
`define CBSC_POS_HI 3
`define CBSC_POS_LO 0
// Mask of writable bits; bits 12..5 are reserved.
`define CBSC_WMASK 16'hE01F
// Control and status registers of this block.
`define CBSC_ADDR_CTRL 12'h380
`define CBSC_ADDR_STAT 12'h384
// Conversion time of one step, in ns, and derived cycles at 50 MHz.
`define CBSC_CLK_NS 20
`define CBSC_CONV_NS 1000
`define CBSC_CONV_CYC ((`CBSC_CONV_NS + `CBSC_CLK_NS - 1) / `CBSC_CLK_NS)
// Positive input codes.
`define CBSC_POS_TEMP 4'h8
`define CBSC_POS_SHORT 4'h9
`define CBSC_POS_TDAC 4'hA
`define CBSC_POS_IO4 4'hC
`define CBSC_POS_AP103 4'hE
`define CBSC_POS_DP103 4'hF
// Bus responses.
`define CBSC_RESP_OKAY 2'h0
`define CBSC_RESP_SLVERR 2'h2
`endif

// ===== rtl/cbsc_step_decode.v
// Decodes one stored step entry into converter mux and gain settings.
// Assumes the entry comes from a register on the same clock.
`timescale 1ns/1ns
`include "cbsc_consts.vh"
module cbsc_step_decode (
  input wire [15:0] cfg, // stored step entry
  output reg [2:0] gain_val, // gain factor 1, 2 or 4
  output reg [3:0] pos_sel, // positive input code
  output reg neg_auto, // negative input chosen automatically
  output reg neg_is_in7 // negative input is external input seven
);
  always @* begin
    case (cfg[`CBSC_GAIN_HI:`CBSC_GAIN_LO])
      2'h0: gain_val = 3'h1;
      2'h1: gain_val = 3'h2;
      default: gain_val = 3'h4;
    endcase
    pos_sel = cfg[`CBSC_POS_HI:`CBSC_POS_LO];
    // Every code above seven is an internal source with its own return.
    neg_auto = cfg[`CBSC_POS_HI];
    neg_is_in7 = cfg[`CBSC_NEG_BIT] & ~cfg[`CBSC_POS_HI];
  end
endmodule

// ===== rtl/cbsc_top.v
// Step 14 and 15 configuration of the converter B sequencer, with an AXI4-Lite slave.
// Assumes one clock core_clk and a synchronous active-high reset rst.
//
// How it works
// - Bit 15 enables or disables the step.
// - Gain codes 00,01,1x give 1,2,4.
// - Bits 12..5 unwritable, read zero.
// - Bit 4: analog ground or input seven.
// - Positive codes 0..7 select external inputs.
// - Codes 8,9,A: temperature, short, test DAC.
// - Codes C,E,F: supply monitors, scaled.
// - Auto-negative sources ignore the negative bit.
// - Step 15 at DFh, reset 000Fh.
// - Step 14 at DEh, reset 000Eh.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "cbsc_consts.vh"
module cbsc_top #(
  parameter CONV_CYC = `CBSC_CONV_CYC // cycles one step conversion lasts
) (
  input wire core_clk, // clock, 50 MHz
  input wire rst, // synchronous reset, active high
  input wire [11:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [11:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  output reg conv_active, // converter busy on a step
  output reg [3:0] conv_pos_sel, // positive input code applied
  output reg conv_neg_is_in7, // negative input is input seven
  output reg conv_neg_auto, // negative input chosen automatically
  output reg [2:0] conv_gain, // gain factor applied
  output reg [3:0] conv_step, // step number being converted
  output reg step_done // pulse at end of each enabled step
);
  localparam ST_IDLE = 3'b001;
  localparam ST_PICK = 3'b010;
  localparam ST_CONV = 3'b100;

  reg [15:0] step14_cfg_r;
  reg [15:0] step15_cfg_r;
  reg run_r;
  reg [2:0] state_r;
  reg cur_r;
  reg [15:0] conv_cnt_r;
  reg [11:0] awaddr_r;
  reg aw_held_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_held_r;
  reg [7:0] skip_cnt_r;

  wire step14_enable;
  wire step15_enable;
  wire [2:0] dec_gain;
  wire [3:0] dec_pos;
  wire dec_neg_auto;
  wire dec_neg_in7;
  wire [15:0] cur_cfg;
  wire do_write;
  wire [15:0] wmask16;
  wire [15:0] wval16;

  assign step14_enable = step14_cfg_r[`CBSC_EN_BIT];
  assign step15_enable = step15_cfg_r[`CBSC_EN_BIT];
  assign cur_cfg = cur_r ? step15_cfg_r : step14_cfg_r;

  cbsc_step_decode u_dec (
    .cfg(cur_cfg),
    .gain_val(dec_gain),
    .pos_sel(dec_pos),
    .neg_auto(dec_neg_auto),
    .neg_is_in7(dec_neg_in7)
  );

  // Address and data are latched separately so they may arrive in either order.
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

  // Byte strobes expand to a bit mask over the low half-word.
  assign wmask16 = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}} & `CBSC_WMASK;
  assign wval16 = wdata_r[15:0];

  always @(posedge core_clk) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CBSC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case ({awaddr_r[11:2], 2'b00})
          `CBSC_ADDR_STEP14, `CBSC_ADDR_STEP15, `CBSC_ADDR_CTRL, `CBSC_ADDR_STAT: s_axi_bresp <= `CBSC_RESP_OKAY;
          default: s_axi_bresp <= `CBSC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      step14_cfg_r <= `CBSC_RST_STEP14;
      step15_cfg_r <= `CBSC_RST_STEP15;
      run_r <= 1'b0;
    end else if (do_write) begin
      case ({awaddr_r[11:2], 2'b00})
        `CBSC_ADDR_STEP14: step14_cfg_r <= (step14_cfg_r & ~wmask16) | (wval16 & wmask16);
        `CBSC_ADDR_STEP15: step15_cfg_r <= (step15_cfg_r & ~wmask16) | (wval16 & wmask16);
        `CBSC_ADDR_CTRL: begin
          if (wstrb_r[0]) begin
            run_r <= wdata_r[0];
          end
        end
        default: run_r <= run_r;
      endcase
    end
  end

  // Read side answers one cycle after the address is taken.
  always @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CBSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CBSC_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        `CBSC_ADDR_STEP14: s_axi_rdata <= {16'h0000, step14_cfg_r};
        `CBSC_ADDR_STEP15: s_axi_rdata <= {16'h0000, step15_cfg_r};
        `CBSC_ADDR_CTRL: s_axi_rdata <= {31'h00000000, run_r};
        `CBSC_ADDR_STAT: s_axi_rdata <= {16'h0000, skip_cnt_r, 3'h0, cur_r, 1'b0, state_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `CBSC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // The sequencer alternates step 14 and step 15 while run is set.
  always @(posedge core_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cur_r <= 1'b0;
      conv_cnt_r <= 16'h0000;
      skip_cnt_r <= 8'h00;
      conv_active <= 1'b0;
      conv_pos_sel <= 4'h0;
      conv_neg_is_in7 <= 1'b0;
      conv_neg_auto <= 1'b0;
      conv_gain <= 3'h1;
      conv_step <= 4'h0;
      step_done <= 1'b0;
    end else begin
      step_done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          conv_active <= 1'b0;
          cur_r <= 1'b0;
          if (run_r) begin
            state_r <= ST_PICK;
          end
        end
        ST_PICK: begin
          if (!run_r) begin
            state_r <= ST_IDLE;
          end else if ((cur_r ? step15_enable : step14_enable)) begin
            conv_active <= 1'b1;
            conv_pos_sel <= dec_pos;
            conv_neg_is_in7 <= dec_neg_in7;
            conv_neg_auto <= dec_neg_auto;
            conv_gain <= dec_gain;
            conv_step <= cur_r ? 4'hF : 4'hE;
            conv_cnt_r <= CONV_CYC[15:0] - 16'h0001;
            state_r <= ST_CONV;
          end else begin
            skip_cnt_r <= skip_cnt_r + 8'h01;
            cur_r <= ~cur_r;
          end
        end
        ST_CONV: begin
          if (conv_cnt_r == 16'h0000) begin
            conv_active <= 1'b0;
            step_done <= 1'b1;
            cur_r <= ~cur_r;
            state_r <= ST_PICK;
          end else begin
            conv_cnt_r <= conv_cnt_r - 16'h0001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== tb/cbsc_top_monitor.sv
// Checker for the converter B step configuration block.
// Assumes it is bound to cbsc_top, one clock, synchronous reset.
`timescale 1ns/1ns
module cbsc_top_monitor #(
  parameter CONV_CYC = 4 // cycles of one conversion
) (
  input wire core_clk, input wire rst, // clock, reset
  input wire s_axi_awvalid, input wire s_axi_awready, input wire s_axi_wvalid, input wire s_axi_wready, // write
  input wire s_axi_bvalid, input wire s_axi_bready, // write answer
  input wire s_axi_arvalid, input wire s_axi_arready, input wire s_axi_rvalid, input wire s_axi_rready, // read
  input wire [11:0] s_axi_araddr, // read address
  input wire [31:0] s_axi_rdata, // read data
  input wire conv_active, input wire [3:0] conv_pos_sel, input wire conv_neg_auto, // settings
  input wire [2:0] conv_gain, input wire [3:0] conv_step, input wire step_done // progress
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Remembers whether the read under way targets a step entry; only step entries get the reserved-bit check.
  reg rd_step_r;
  always @(posedge core_clk) begin
    if (rst) begin
      rd_step_r <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_step_r <= ({s_axi_araddr[11:2], 2'b00} == 12'h378) || ({s_axi_araddr[11:2], 2'b00} == 12'h37C);
    end
  end
  // Both channels are latched first, so the answer appears on the second edge after the handshake.
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  rd_zero_a: assert property (s_axi_rvalid && rd_step_r |-> (s_axi_rdata & 32'hFFFF1FE0) == 32'h00000000)
    else $error("reserved bits set");
  gain_code_a: assert property (conv_active |-> conv_gain inside {3'h1, 3'h2, 3'h4})
    else $error("bad gain");
  neg_auto_a: assert property (conv_active |-> conv_neg_auto == conv_pos_sel[3])
    else $error("bad automatic negative");
  step_num_a: assert property (conv_active |-> conv_step inside {4'hE, 4'hF})
    else $error("bad step number");
  done_pulse_a: assert property (step_done |=> !step_done)
    else $error("done too long");
  done_end_a: assert property (step_done |-> $past(conv_active))
    else $error("done without conversion");
  conv_hold_a: assert property (conv_active && $past(conv_active) && !$past(step_done) |-> $stable(conv_gain))
    else $error("gain changed in step");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (step_done && conv_step == 4'hF);
  cover property (conv_active && conv_neg_auto);
endmodule
bind cbsc_top cbsc_top_monitor #(.CONV_CYC(CONV_CYC)) u_mon (
  .core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .conv_active(conv_active), .conv_pos_sel(conv_pos_sel),
  .conv_neg_auto(conv_neg_auto), .conv_gain(conv_gain), .conv_step(conv_step), .step_done(step_done)
);

// ===== tb/test_cbsc_top.sv
// Bench for the converter B step configuration block.
// Assumes rtl/ sources and the bound checker.
`timescale 1ns/1ns
`include "cbsc_consts.vh"
module test_cbsc_top;
  localparam [31:0] POS_LIST = 32'hFECA9870;
  localparam [11:0] A14 = `CBSC_ADDR_STEP14;
  localparam [11:0] A15 = `CBSC_ADDR_STEP15;
  localparam [1:0] OK = `CBSC_RESP_OKAY;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  reg [31:0] s_axi_wdata = 32'h00000000;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire step_done, conv_active, conv_neg_is_in7, conv_neg_auto;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] conv_pos_sel, conv_step;
  wire [2:0] conv_gain;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer i;
  reg [3:0] p;
  reg [1:0] g;
  reg ng;
  always #10 core_clk = ~core_clk;
  cbsc_top #(.CONV_CYC(4)) uut (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .conv_active(conv_active), .conv_pos_sel(conv_pos_sel), .conv_neg_is_in7(conv_neg_is_in7),
    .conv_neg_auto(conv_neg_auto), .conv_gain(conv_gain), .conv_step(conv_step), .step_done(step_done)
  );
  task conclude;
    begin
      if (error_cnt == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task hang;
    begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  // One bus access; write or read, released only on its own handshake.
  task acc(input wr, input [11:0] a, input [31:0] d, input [31:0] eq, input [1:0] er);
    integer n;
    reg done;
    reg [31:0] q;
    reg [1:0] r;
    begin
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      done = 1'b0;
      q = 32'h00000000;
      r = 2'h3;
      for (n = 0; n < 200 && !done; n = n + 1) begin
        @(posedge core_clk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_bvalid && s_axi_bready) begin
          done = 1'b1;
          r = s_axi_bresp;
        end
        if (s_axi_rvalid && s_axi_rready) begin
          done = 1'b1;
          q = s_axi_rdata;
          r = s_axi_rresp;
        end
      end
      if (!done) hang;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      chk(q, eq);
      chk({30'h0, r}, {30'h0, er});
    end
  endtask
  // Waits for a done pulse (sel 1) or for a conversion under way (sel 0).
  task wt(input sel);
    integer n;
    begin
      @(negedge core_clk);
      for (n = 0; n < 300 && !(sel ? step_done === 1'b1 : conv_active === 1'b1 && step_done === 1'b0); n = n + 1)
        @(negedge core_clk);
      if (n >= 300) hang;
    end
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    acc(0, A14, 0, 32'h0000000E, OK);
    acc(0, A15, 0, 32'h0000000F, OK);
    acc(1, A14, 32'hFFFFFFFF, 0, OK);
    acc(0, A14, 0, 32'h0000E01F, OK);
    acc(1, A15, 32'h00007FF0, 0, OK);
    acc(0, A15, 0, 32'h00006010, OK);
    acc(0, 12'h3F0, 0, 0, `CBSC_RESP_SLVERR);
    acc(1, 12'h3F0, 32'h00000001, 0, `CBSC_RESP_SLVERR);
    acc(1, A15, 32'h0000000F, 0, OK);
    for (i = 0; i < 8; i = i + 1) begin
      p = POS_LIST[i*4 +: 4];
      g = i[1:0];
      ng = (i != 1);
      acc(1, A14, {16'h0, 1'b1, g, 8'h00, ng, p}, 0, OK);
      acc(1, `CBSC_ADDR_CTRL, 32'h00000001, 0, OK);
      wt(1);
      wt(0);
      chk({28'h0, conv_step}, 32'h0000000E);
      chk({28'h0, conv_pos_sel}, {28'h0, p});
      chk({29'h0, conv_gain}, {29'h0, (g == 2'h0) ? 3'h1 : (g == 2'h1) ? 3'h2 : 3'h4});
      chk({31'h0, conv_neg_auto}, {31'h0, p[3]});
      chk({31'h0, conv_neg_is_in7}, {31'h0, ng & !p[3]});
    end
    acc(1, A14, 32'h0000000E, 0, OK);
    acc(1, A15, 32'h0000800F, 0, OK);
    wt(1);
    wt(0);
    chk({28'h0, conv_step}, 32'h0000000F);
    chk({28'h0, conv_pos_sel}, 32'h0000000F);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    acc(0, A15, 0, 32'h0000000F, OK);
    acc(0, A14, 0, 32'h0000000E, OK);
    acc(0, `CBSC_ADDR_CTRL, 0, 32'h00000000, OK);
    acc(0, `CBSC_ADDR_STAT, 0, 32'h00000001, OK);
    conclude;
  end
endmodule
